// *** dv/dcs_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// fieldbus master: one word pair per send call, launched off the falling edge
module dcs_master (
  // clock
  input wire logic clk_sys,
  // words to the card
  output logic new_words,
  output logic [15:0] drive_command_word,
  output logic [15:0] speed_setpoint_word,
  // words from the card
  input wire logic [15:0] drive_state_word
);
  initial begin
    new_words = 1'b0;
    drive_command_word = 16'h0000;
    speed_setpoint_word = 16'h0000;
  end
  task automatic send(input logic [15:0] cmd, input logic [15:0] sp);
    @(negedge clk_sys);
    new_words = 1'b1;
    drive_command_word = cmd;
    speed_setpoint_word = sp;
    @(negedge clk_sys);
    new_words = 1'b0;
    // words are stale outside the pulse, so never leave them looking valid
    drive_command_word = ~cmd;
    speed_setpoint_word = ~sp;
  endtask : send
  task automatic start_run(input logic [15:0] sp);
    int i;
    send(16'h047e, sp);
    for (i = 0; i < 20 && drive_state_word[0] !== 1'b1; i++) @(negedge clk_sys);
    if (drive_state_word[0] === 1'b1) begin
      send(16'h047f, sp);
    end
  endtask : start_run
endmodule : dcs_master
`default_nettype wire

// *** dv/tb_drive_control_status_words.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_drive_control_status_words import dcs_pkg::*; ;
  logic clk_sys, reset, new_words, fault_flag;
  logic [15:0] cmd_w, sp_w, sw, speed, dstep, det_lvl, qdec;
  logic run_en, out_en, coast, qstop, rev, frst;
  int bad_count, n_tests;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  dcs_master m_u (.clk_sys(clk_sys), .new_words(new_words), .drive_command_word(cmd_w),
    .speed_setpoint_word(sp_w), .drive_state_word(sw));
  dcs_core #(.W(16)) dut_u (.clk_sys(clk_sys), .reset(reset), .new_words(new_words),
    .drive_command_word(cmd_w), .speed_setpoint_word(sp_w),
    .freq_detect_level_setting(det_lvl), .accel_step(16'h0100), .decel_step(16'h0100),
    .decel_time_setting(qdec), .fault_flag(fault_flag), .run_enable(run_en),
    .output_enable(out_en), .coast_stop_request(coast), .quick_stop_request(qstop),
    .reverse(rev), .fault_reset_request(frst), .decel_step_used(dstep),
    .drive_state_word(sw), .speed_actual_word(speed));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // bounded wait on one state word bit, a timeout shows as a mismatch
  task automatic wait_sw(input int b, input logic v);
    int i;
    for (i = 0; i < 300 && sw[b] !== v; i++) @(negedge clk_sys);
    chk({15'h0000, sw[b]}, {15'h0000, v});
  endtask : wait_sw
  task automatic go;
    m_u.start_run(16'h1000);
    wait_sw(STS_AT_SP_A, 1'b1);
    chk(sw & 16'h0b06, 16'h0b06);
    chk(speed, 16'h1000);
    chk({14'h0000, out_en, run_en}, 16'h0003);
    chk({15'h0000, sw[STS_INHIBIT]}, {15'h0000, ~sw[STS_READY_ON]});
  endtask : go
  task automatic stop;
    m_u.send(16'h047e, 16'h1000);
    wait_sw(STS_READY_ON, 1'b1);
    chk(speed, 16'h0000);
    chk(sw & 16'h0fff, 16'h0431);
    chk({15'h0000, run_en}, 16'h0000);
  endtask : stop
  initial begin
    #500000;
    bad_count++;
    finish_test;
  end
  initial begin
    bad_count = 0;
    n_tests = 0;
    reset = 1'b1;
    fault_flag = 1'b0;
    det_lvl = 16'h0800;
    qdec = 16'h0200;
    cyc(3);
    chk(sw, 16'h0040);
    reset = 1'b0;
    cyc(1);
    chk(sw, 16'h0040);
    go;
    det_lvl = 16'h1001;
    cyc(3);
    chk({15'h0000, sw[STS_LEVEL]}, 16'h0000);
    det_lvl = 16'h0800;
    // --------------------------------------------------------
    // freeze, then hold at zero
    // --------------------------------------------------------
    m_u.send(16'h045f, 16'h2000);
    cyc(20);
    chk(speed, 16'h1000);
    m_u.send(16'h046f, 16'h2000);
    cyc(40);
    chk(speed, 16'h0000);
    chk({15'h0000, sw[STS_RUNNING]}, 16'h0000);
    stop;
    go;
    m_u.send(16'h0c7f, 16'h1000);
    cyc(4);
    chk({15'h0000, rev}, 16'h0001);
    m_u.send(16'h047f, 16'hf000);
    cyc(4);
    chk({15'h0000, rev}, 16'h0001);
    m_u.send(16'h007e, 16'h1000);
    cyc(4);
    chk({15'h0000, sw[STS_REMOTE]}, 16'h0000);
    chk({14'h0000, run_en, rev}, 16'h0003);
    stop;
    go;
    m_u.send(16'h047b, 16'h1000);
    cyc(4);
    chk({15'h0000, qstop}, 16'h0001);
    chk(dstep, 16'h0200);
    chk(sw & 16'h0030, 16'h0010);
    chk(speed, 16'h0c00);
    cyc(40);
    chk(speed, 16'h0000);
    stop;
    go;
    m_u.send(16'h047d, 16'h1000);
    cyc(4);
    chk({15'h0000, coast}, 16'h0001);
    chk(sw & 16'h0071, 16'h0060);
    cyc(40);
    stop;
    go;
    m_u.send(16'h0477, 16'h1000);
    cyc(4);
    chk({15'h0000, out_en}, 16'h0000);
    stop;
    // --------------------------------------------------------
    // trip and fault reset
    // --------------------------------------------------------
    fault_flag = 1'b1;
    cyc(4);
    chk(sw & 16'h0049, 16'h0048);
    fault_flag = 1'b0;
    m_u.send(16'h04fe, 16'h1000);
    cyc(4);
    chk({15'h0000, frst}, 16'h0001);
    chk(sw & 16'h0009, 16'h0000);
    m_u.send(16'h047e, 16'h1000);
    wait_sw(STS_READY_ON, 1'b1);
    m_u.send(16'hf77e, 16'h1000);
    cyc(4);
    chk(sw & 16'hf081, 16'h0001);
    finish_test;
  end
endmodule : tb_drive_control_status_words
`default_nettype wire

// *** hw/dcs_core.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - command bit 0 is the run command, on when set.
// - command bit 1 clear coasts the motor; set is a readiness request.
// - command bit 2 clear stops using the quick decel time; set is readiness.
// - command bit 3 clear shuts the output down; set permits operation.
// - command bit 4 clear holds output frequency at zero.
// - command bit 5 clear freezes the ramp at present frequency.
// - command bit 7 resets a fault and leaves the card not ready.
// - command bit 10 clear ignores the command and setpoint words.
// - command bit 11 flips direction: clear keeps the setpoint sign, set reverses it.
// - state bit 0 shows ready to switch on; bit 6 is its inverse.
// - state bit 3 shows drive tripped.
// - state bits 4 and 5 mirror command bits 1 and 2.
// - state bits 8 and 9 both show output at setpoint.
// - state bit 10 set when link frequency or run command is in effect.
// - state bit 11 set when output at or above detect level.
// - after reset the profile sits in S1, not ready.
// - command bits advance S2, S3, S4 in order; motor runs in S4 and in S5 until stopped.
// - run removed in S4 goes to S5, then S2 or S1 once stopped.
// - running needs command bits 4, 5, 6 and 10 all set.
// - frequency words scale max frequency to 4000 hex, two's complement reverse.
module dcs_core import dcs_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // cyclic words from the master, new_words pulses when both are valid
  input wire logic new_words,
  input wire logic [15:0] drive_command_word,
  input wire logic [15:0] speed_setpoint_word,
  // drive settings, same scale as the frequency words
  input wire logic [15:0] freq_detect_level_setting,
  input wire logic [15:0] accel_step,
  input wire logic [15:0] decel_step,
  input wire logic [15:0] decel_time_setting,
  // drive side
  input wire logic fault_flag,
  output logic run_enable,
  output logic output_enable,
  output logic coast_stop_request,
  output logic quick_stop_request,
  output logic reverse,
  output logic fault_reset_request,
  output logic [15:0] decel_step_used,
  // words back to the master
  output logic [15:0] drive_state_word,
  output logic [15:0] speed_actual_word
);
  // ------------------------------------------------------------
  // latched command
  // ------------------------------------------------------------
  logic [15:0] cmd_reg;
  logic [15:0] sp_reg;
  logic linked_reg;
  wire logic take = new_words && drive_command_word[CMD_LINK_EN];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_reg <= WORD_RESET;
      sp_reg <= WORD_RESET;
      linked_reg <= 1'b0;
    end else begin
      if (take) cmd_reg <= drive_command_word & 16'h0cff;
      if (take) sp_reg <= speed_setpoint_word;
      if (new_words) linked_reg <= drive_command_word[CMD_LINK_EN];
    end
  end
  wire logic c_run = cmd_reg[CMD_RUN];
  wire logic c_coast_n = cmd_reg[CMD_COAST_N];
  wire logic c_qstop_n = cmd_reg[CMD_QSTOP_N];
  wire logic c_enop = cmd_reg[CMD_ENABLE_OP];
  wire logic c_rst = cmd_reg[CMD_FAULT_RST];
  wire logic gates_ok = cmd_reg[CMD_RAMP_EN] && cmd_reg[CMD_RAMP_GO]
                        && cmd_reg[CMD_SETPT_EN] && cmd_reg[CMD_LINK_EN];
  // ------------------------------------------------------------
  // profile state machine
  // ------------------------------------------------------------
  dcs_state_t state_reg;
  dcs_state_t state_next;
  logic stopped;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NOT_READY: begin
        if (!fault_flag && !c_rst && !c_run && c_coast_n && c_qstop_n)
          state_next = ST_READY_ON;
      end
      ST_READY_ON: begin
        if (fault_flag || c_rst || !c_coast_n || !c_qstop_n) state_next = ST_NOT_READY;
        else if (c_run) state_next = ST_READY_RUN;
      end
      ST_READY_RUN: begin
        if (fault_flag || c_rst || !c_coast_n || !c_qstop_n) state_next = ST_NOT_READY;
        else if (!c_run) state_next = ST_READY_ON;
        else if (c_enop) state_next = ST_RUNNING;
      end
      ST_RUNNING: begin
        // quick stop ramps down in S5 at the quick rate instead of dropping the output
        if (fault_flag || c_rst || !c_coast_n || !c_enop) state_next = ST_NOT_READY;
        else if (!c_run || !c_qstop_n) state_next = ST_STOPPING;
      end
      ST_STOPPING: begin
        if (fault_flag || c_rst || !c_coast_n) state_next = ST_NOT_READY;
        else if (stopped) state_next = c_qstop_n ? ST_READY_ON : ST_NOT_READY;
      end
      default: state_next = ST_NOT_READY;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) state_reg <= ST_NOT_READY;
    else state_reg <= state_next;
  end
  // ------------------------------------------------------------
  // ramp and drive controls
  // ------------------------------------------------------------
  // a frozen ramp still sits in S4, so the freeze keys off the state, not the gates
  wire logic in_s4 = (state_reg == ST_RUNNING);
  wire logic in_run = in_s4 && gates_ok;
  wire logic in_stop = (state_reg == ST_STOPPING);
  wire logic sp_neg = sp_reg[15];
  wire logic [15:0] sp_mag = sp_neg ? 16'(-sp_reg) : sp_reg;
  wire logic [15:0] sp_lim = (sp_mag > FREQ_FULL_SCALE) ? FREQ_FULL_SCALE : sp_mag;
  wire logic [15:0] ramp_target = in_run ? sp_lim : 16'h0000;
  wire logic hold_zero = !cmd_reg[CMD_RAMP_EN] || !c_enop || !c_coast_n
                         || !(in_s4 || in_stop);
  wire logic freeze = in_s4 && !cmd_reg[CMD_RAMP_GO];
  wire logic [15:0] down_step = c_qstop_n ? decel_step : decel_time_setting;
  logic [15:0] level;
  dcs_ramp #(.W(16)) u_ramp (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold_zero(hold_zero),
    .freeze(freeze),
    .target(ramp_target),
    .step_up(accel_step),
    .step_down(down_step),
    .level(level)
  );
  assign stopped = (level == 16'h0000);
  wire logic dir_rev = cmd_reg[CMD_REVERSE] ^ sp_neg;
  // ------------------------------------------------------------
  // state word
  // ------------------------------------------------------------
  wire logic ready_on = (state_reg == ST_READY_ON);
  wire logic ready_run = (state_reg == ST_READY_RUN) || (state_reg == ST_RUNNING);
  wire logic at_sp = in_run && (level == sp_lim);
  wire logic at_lvl = (level >= freq_detect_level_setting);
  logic [15:0] sts_next;
  always_comb begin
    sts_next = 16'h0000;
    sts_next[STS_READY_ON] = ready_on;
    sts_next[STS_READY_RUN] = ready_run;
    sts_next[STS_RUNNING] = in_run;
    sts_next[STS_FAULT] = fault_flag;
    sts_next[STS_COAST] = c_coast_n;
    sts_next[STS_QSTOP] = c_qstop_n;
    sts_next[STS_INHIBIT] = !ready_on;
    sts_next[STS_AT_SP_A] = at_sp;
    sts_next[STS_AT_SP_B] = at_sp;
    sts_next[STS_REMOTE] = linked_reg;
    sts_next[STS_LEVEL] = at_lvl;
  end
  logic [15:0] sts_reg;
  logic [15:0] act_reg;
  logic run_reg, oe_reg, coast_reg, qs_reg, rev_reg, rst_reg;
  logic [15:0] dstep_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sts_reg <= 16'h0040;
      act_reg <= WORD_RESET;
      run_reg <= 1'b0;
      oe_reg <= 1'b0;
      coast_reg <= 1'b0;
      qs_reg <= 1'b0;
      rev_reg <= 1'b0;
      rst_reg <= 1'b0;
      dstep_reg <= WORD_RESET;
    end else begin
      sts_reg <= sts_next;
      act_reg <= dir_rev ? 16'(-level) : level;
      run_reg <= in_run || ((in_s4 || in_stop) && !stopped);
      oe_reg <= c_enop && (in_run || in_stop);
      coast_reg <= !c_coast_n;
      qs_reg <= !c_qstop_n;
      rev_reg <= dir_rev;
      rst_reg <= c_rst;
      dstep_reg <= down_step;
    end
  end
  assign drive_state_word = sts_reg;
  assign speed_actual_word = act_reg;
  assign run_enable = run_reg;
  assign output_enable = oe_reg;
  assign coast_stop_request = coast_reg;
  assign quick_stop_request = qs_reg;
  assign reverse = rev_reg;
  assign fault_reset_request = rst_reg;
  assign decel_step_used = dstep_reg;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_reset_not_ready: assert property (@(posedge clk_sys) disable iff (reset)
    c_rst |=> state_reg == ST_NOT_READY) else $error("fault reset left card ready");
  chk_inhibit_inverse: assert property (@(posedge clk_sys) disable iff (reset)
    sts_reg[STS_INHIBIT] == !sts_reg[STS_READY_ON]) else $error("bit 6 not inverse of bit 0");
  chk_mirror_bits: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 sts_reg[STS_COAST] == $past(c_coast_n) && sts_reg[STS_QSTOP] == $past(c_qstop_n))
    else $error("state word mirror wrong");
  chk_fault_bit: assert property (@(posedge clk_sys) disable iff (reset)
    fault_flag |=> sts_reg[STS_FAULT]) else $error("fault bit not shown");
  chk_link_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    new_words && !drive_command_word[CMD_LINK_EN] |=> $stable(cmd_reg))
    else $error("word taken while link disabled");
  chk_run_gates: assert property (@(posedge clk_sys) disable iff (reset)
    sts_reg[STS_RUNNING] |-> $past(gates_ok)) else $error("running without gates");
  chk_stop_path: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_RUNNING && state_next != ST_RUNNING && c_coast_n && !c_rst
    && c_enop && !fault_flag |=> state_reg == ST_STOPPING) else $error("run drop not to S5");
  chk_zero_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !cmd_reg[CMD_RAMP_EN] |=> level == 16'h0000) else $error("frequency not held at zero");
  chk_unused_zero: assert property (@(posedge clk_sys) disable iff (reset)
    sts_reg[15:12] == 4'h0 && !sts_reg[7]) else $error("unused state bits set");
  chk_run_cmd: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_READY_RUN |-> $past(c_run)) else $error("S3 without run command");
  chk_coast_out: assert property (@(posedge clk_sys) disable iff (reset)
    !c_coast_n |=> coast_stop_request && level == 16'h0000)
    else $error("coast request not carried out");
  chk_qstop_step: assert property (@(posedge clk_sys) disable iff (reset)
    !c_qstop_n |=> decel_step_used == $past(decel_time_setting))
    else $error("quick stop not using quick decel");
  chk_enable_off: assert property (@(posedge clk_sys) disable iff (reset)
    !c_enop |=> !output_enable) else $error("output enabled without bit 3");
  chk_freeze_level: assert property (@(posedge clk_sys) disable iff (reset)
    freeze && !hold_zero |=> level == $past(level)) else $error("ramp moved while frozen");
  chk_dir_out: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> reverse == ($past(cmd_reg[CMD_REVERSE]) ^ $past(sp_reg[15])))
    else $error("direction output wrong");
  chk_at_setpoint: assert property (@(posedge clk_sys) disable iff (reset)
    sts_reg[STS_AT_SP_A] == sts_reg[STS_AT_SP_B]) else $error("setpoint bits differ");
  chk_level_flag: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> sts_reg[STS_LEVEL] == ($past(level) >= $past(freq_detect_level_setting)))
    else $error("level flag wrong");
  chk_ready_bits: assert property (@(posedge clk_sys) disable iff (reset)
    sts_reg[STS_RUNNING] |-> sts_reg[STS_READY_RUN]) else $error("running without ready");
  chk_s4_order: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_RUNNING |-> $past(state_reg) == ST_READY_RUN
    || $past(state_reg) == ST_RUNNING) else $error("S4 entered out of order");
  chk_s5_entry: assert property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_STOPPING |-> $past(state_reg) == ST_RUNNING
    || $past(state_reg) == ST_STOPPING) else $error("S5 entered not from S4");
  chk_speed_sign: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> speed_actual_word == (reverse ? 16'(-$past(level)) : $past(level)))
    else $error("actual speed sign wrong");
  chk_scale_limit: assert property (@(posedge clk_sys) disable iff (reset)
    level <= FREQ_FULL_SCALE) else $error("frequency above full scale");
  cov_freeze_hold: cover property (@(posedge clk_sys) disable iff (reset)
    freeze && level != 16'h0000);
  cov_reach_run: cover property (@(posedge clk_sys) disable iff (reset) in_run);
  cov_stop_back: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_STOPPING ##1 state_reg == ST_READY_ON);
  cov_fault_drop: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == ST_RUNNING ##1 state_reg == ST_NOT_READY);
endmodule : dcs_core
`default_nettype wire

// *** hw/dcs_pkg.sv ***
package dcs_pkg;
  // ------------------------------------------------------------
  // command word bit positions
  // ------------------------------------------------------------
  localparam int CMD_RUN = 0;
  localparam int CMD_COAST_N = 1;
  localparam int CMD_QSTOP_N = 2;
  localparam int CMD_ENABLE_OP = 3;
  localparam int CMD_RAMP_EN = 4;
  localparam int CMD_RAMP_GO = 5;
  localparam int CMD_SETPT_EN = 6;
  localparam int CMD_FAULT_RST = 7;
  localparam int CMD_LINK_EN = 10;
  localparam int CMD_REVERSE = 11;
  // ------------------------------------------------------------
  // state word bit positions
  // ------------------------------------------------------------
  localparam int STS_READY_ON = 0;
  localparam int STS_READY_RUN = 1;
  localparam int STS_RUNNING = 2;
  localparam int STS_FAULT = 3;
  localparam int STS_COAST = 4;
  localparam int STS_QSTOP = 5;
  localparam int STS_INHIBIT = 6;
  localparam int STS_AT_SP_A = 8;
  localparam int STS_AT_SP_B = 9;
  localparam int STS_REMOTE = 10;
  localparam int STS_LEVEL = 11;
  // ------------------------------------------------------------
  // scaling and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] FREQ_FULL_SCALE = 16'h4000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ------------------------------------------------------------
  // profile states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_NOT_READY = 5'b00001,
    ST_READY_ON = 5'b00010,
    ST_READY_RUN = 5'b00100,
    ST_RUNNING = 5'b01000,
    ST_STOPPING = 5'b10000
  } dcs_state_t;
endpackage : dcs_pkg

// *** hw/dcs_ramp.sv ***
`timescale 1ns/10ps
`default_nettype none
// ramp generator: magnitude moves toward target by step per tick
module dcs_ramp import dcs_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic hold_zero,
  input wire logic freeze,
  input wire logic [W-1:0] target,
  input wire logic [W-1:0] step_up,
  input wire logic [W-1:0] step_down,
  // result
  output logic [W-1:0] level
);
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;
  wire logic [W:0] up_sum = {1'b0, level_reg} + {1'b0, step_up};
  wire logic [W-1:0] up_val = (up_sum > {1'b0, target}) ? target : up_sum[W-1:0];
  wire logic [W-1:0] dn_val = (level_reg - target < step_down) ? target : level_reg - step_down;
  assign level_next = hold_zero ? '0 :
                      freeze ? level_reg :
                      (level_reg < target) ? up_val :
                      (level_reg > target) ? dn_val : level_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) level_reg <= '0;
    else level_reg <= level_next;
  end
  assign level = level_reg;
endmodule : dcs_ramp
`default_nettype wire
